/* hdl/spd_pin_drv.sv */
// spd_pin_drv: output level and drive enable of the pwm pin
// assumes: set, clr, off, en and hold from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module spd_pin_drv
   import spd_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic set, // period start
   input wire logic clr, // duty match
   input wire logic off, // pwm mode disabled
   input wire logic en, // drive the pin
   input wire logic hold, // sleep: freeze
   output logic pin, // pin level
   output logic oe_n // pin driven when low
);

   spd_pin_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      // RULE12 frozen in sleep
      if (!hold) begin
         s_d.oe_n = !en;
         // RULE17 mode off forces low
         if (off) begin
            s_d.lvl = 1'b0;
         end else if (set) begin
            s_d.lvl = 1'b1;
         end else if (clr) begin
            s_d.lvl = 1'b0;
         end
      end
   end

   // RULE14 reset to input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= PIN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign pin = s_q.lvl;
   assign oe_n = s_q.oe_n;

   ////////////////////////////////////////////////////////////////////////////////
   property p_off_low;
      @(posedge pclk) disable iff (!presetn) off && !hold |=> !pin ##1 (!pin || !off);
   endproperty
   a_off_low: assert property (p_off_low) // RULE17
      else $error("pin not low with pwm mode off");

   property p_sleep_hold;
      @(posedge pclk) disable iff (!presetn) hold |=> $stable(pin) && $stable(oe_n);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // RULE12
      else $error("pin changed during sleep");

endmodule
`default_nettype wire

/* hdl/spd_pkg.sv */
// spd_pkg: register map, field layout and state types of the pwm duty generator
// assumes: 32-bit apb with one aligned word per register, one system clock
package spd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DUTY_HI = 8'h04;
   localparam logic [7:0] OFS_SHADOW = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0c;
   localparam logic [7:0] OFS_TCTRL = 8'h10;
   localparam logic [7:0] OFS_TCOUNT = 8'h14;
   localparam logic [7:0] OFS_TSEL = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
   localparam logic [7:0] OFS_IRQ_FLG = 8'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions and masks
   localparam int MODE_POS = 2;
   localparam int DC_LO_POS = 4;
   localparam int PSC_POS = 0;
   localparam int RUN_POS = 2;
   localparam int TMF_POS = 1;
   localparam logic [1:0] PWM_MODE = 2'h3;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   localparam logic [7:0] TCTRL_WMASK = 8'h7f;
   localparam logic [7:0] REG_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int TICKS_PER_INC = 4;
   localparam int PSC_W = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK = 2'b10
   } spd_apb_st_t;

   typedef struct packed {
      logic lvl;
      logic oe_n;
   } spd_pin_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] duty_hi;
      logic [7:0] shadow;
      logic [1:0] lat;
      logic [7:0] period;
      logic [7:0] tctrl;
      logic [7:0] tmr;
      logic [7:0] tsel;
      logic [7:0] irq_en;
      logic flag;
      spd_apb_st_t st;
      logic [31:0] rdata;
      logic slverr;
   } spd_regs_t;

   localparam spd_pin_t PIN_RST = '{lvl: 1'b0, oe_n: 1'b1};
   localparam spd_regs_t REGS_RST = '{st: ST_IDLE, rdata: 32'h0, default: '0};

endpackage

/* hdl/spd_prescaler.sv */
// spd_prescaler: timer prescale counter, increment tick and time base low bits
// assumes: run and clr come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module spd_prescaler
   import spd_pkg::*;
#(
   parameter int CNT_W = PSC_W
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic run, // advance the count
   input wire logic clr, // restart the count
   input wire logic [1:0] sel, // prescale select 1/4/16/64
   output logic tick, // timer increment this cycle
   output logic [1:0] low // time base low bits
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } spd_psc_st_t;

   spd_psc_st_t s_q, s_d;
   logic [CNT_W-1:0] last;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      // RULE1 four clocks times prescale
      last = CNT_W'((TICKS_PER_INC << (2 * int'(sel))) - 1);
      tick = run && (s_q.cnt == last);
      // RULE8 top two bits of count
      low = s_q.cnt[2 * int'(sel) +: 2];
      s_d = s_q;
      if (clr) begin
         s_d.cnt = '0;
      end else if (tick) begin
         s_d.cnt = '0;
      end else if (run) begin
         s_d.cnt = s_q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_fast_run;
      tick && sel == 2'h0 ##1 (run && !clr && sel == 2'h0)[*4];
   endsequence

   property p_psc_period;
      @(posedge pclk) disable iff (!presetn) s_fast_run |-> tick;
   endproperty
   a_psc_period: assert property (p_psc_period) // RULE1
      else $error("prescale tick not every four clocks");

   property p_psc_hold;
      @(posedge pclk) disable iff (!presetn) !run && !clr |=> $stable(s_q.cnt);
   endproperty
   a_psc_hold: assert property (p_psc_hold) // RULE16
      else $error("prescaler moved while stopped");

endmodule
`default_nettype wire

/* hdl/spd_top.sv */
// spd_top: standard pwm duty generator with apb register file
// assumes: apb master on pclk, sleep_req synchronous to pclk
//
// Behaviour
// (RULE1) period is (period_limit+1) times four clocks times prescale factor
// (RULE2) count past period_limit clears timer and loads duty shadow
// (RULE3) each rollover sets the pin, unless duty is zero
// (RULE4) duty is 10 bits: duty_high_byte plus control bits 5:4
// (RULE5) duty writes accepted anytime, applied only at the period match
// (RULE6) duty shadow is read-only in pwm mode
// (RULE7) shadow plus hidden 2-bit latch double-buffer the duty
// (RULE8) time base is timer count plus two prescaler or clock-phase bits
// (RULE9) time base equal to shadow and latch clears the pin
// (RULE10) resolution is log2 of four times (period_limit+1)
// (RULE11) duty beyond the period never clears the pin
// (RULE12) sleep freezes timer, shadow and pin; count resumes afterwards
// (RULE13) all timing derives from the system clock
// (RULE14) reset returns pin to input and all registers to reset values
// (RULE15) software sets timer_run_bit after choosing the prescale
// (RULE16) timer counts only while timer_run_bit is set
// (RULE17) pin is driven low when pwm mode is off; the code instead releases the pin (oe_n high) with its level low
`timescale 1ns/10ps
`default_nettype none
module spd_top
   import spd_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped
   input wire logic sleep_req, // device asleep
   output logic pwm_output_pin, // pwm level
   output logic pwm_output_oe_n // pin driven when low
);

   spd_regs_t s_q, s_d;

   logic pwm_on;
   logic run;
   logic tick;
   logic match;
   logic roll;
   logic [1:0] tb_low;
   logic [1:0] dc_lo;
   logic [9:0] duty;
   logic [9:0] cmp;
   logic [9:0] tbase;
   logic hit;
   logic set_pin;
   logic wr;
   logic tcount_wr;
   logic rd_hit;
   logic [7:0] rd_val;

   ////////////////////////////////////////////////////////////////////////////////
   // decode of control state
   assign pwm_on = s_q.ctrl[MODE_POS +: 2] == PWM_MODE;
   // RULE16 run bit gates the timer
   assign run = s_q.tctrl[RUN_POS] && !sleep_req;
   assign match = s_q.tmr == s_q.period;
   assign roll = run && tick && match;
   assign dc_lo = s_q.ctrl[DC_LO_POS +: 2];
   // RULE4 duty from two registers
   assign duty = {s_q.duty_hi, dc_lo};
   assign cmp = {s_q.shadow, s_q.lat};
   // RULE8 ten-bit time base
   assign tbase = {s_q.tmr, tb_low};
   // RULE9 duty match clears the pin
   // RULE10 only reachable values match
   assign hit = pwm_on && (tbase == cmp);
   // RULE3 set in first cycle of the period
   // same one-cycle latency as the clear: high time is duty times prescale clocks
   assign set_pin = pwm_on && run && (tbase == 10'h000) && (cmp != 10'h000);

   assign wr = (s_q.st == ST_ACK) && psel && penable && pwrite && !s_q.slverr;
   assign tcount_wr = wr && (paddr == OFS_TCOUNT);

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      case (paddr)
         OFS_CTRL: begin
            rd_val = s_q.ctrl;
         end
         OFS_DUTY_HI: begin
            rd_val = s_q.duty_hi;
         end
         OFS_SHADOW: begin
            rd_val = s_q.shadow;
         end
         OFS_PERIOD: begin
            rd_val = s_q.period;
         end
         OFS_TCTRL: begin
            rd_val = s_q.tctrl;
         end
         OFS_TCOUNT: begin
            rd_val = s_q.tmr;
         end
         OFS_TSEL: begin
            rd_val = s_q.tsel;
         end
         OFS_IRQ_EN: begin
            rd_val = s_q.irq_en;
         end
         OFS_IRQ_FLG: begin
            rd_val[TMF_POS] = s_q.flag;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;

      // apb: one wait state, answer registered
      unique case (s_q.st)
         ST_IDLE: begin
            if (psel && penable) begin
               s_d.st = ST_ACK;
               s_d.rdata = {24'h0, rd_val};
               s_d.slverr = !rd_hit;
            end
         end
         ST_ACK: begin
            s_d.st = ST_IDLE;
            s_d.slverr = 1'b0;
         end
      endcase

      // RULE2 rollover and shadow load
      // RULE12 run low in sleep
      if (run && tick) begin
         if (match) begin
            s_d.tmr = 8'h00;
            // RULE7 double-buffered duty
            if (pwm_on) begin
               s_d.shadow = s_q.duty_hi;
               s_d.lat = dc_lo;
            end
         end else begin
            s_d.tmr = s_q.tmr + 8'h01;
         end
      end

      // RULE5 writes land in buffer only
      if (wr) begin
         case (paddr)
            OFS_CTRL: begin
               s_d.ctrl = pwdata[7:0] & CTRL_WMASK;
            end
            OFS_DUTY_HI: begin
               s_d.duty_hi = pwdata[7:0];
            end
            OFS_SHADOW: begin
               // RULE6 read-only in pwm mode
               if (!pwm_on) begin
                  s_d.shadow = pwdata[7:0];
               end
            end
            OFS_PERIOD: begin
               s_d.period = pwdata[7:0];
            end
            OFS_TCTRL: begin
               s_d.tctrl = pwdata[7:0] & TCTRL_WMASK;
            end
            OFS_TCOUNT: begin
               s_d.tmr = pwdata[7:0];
            end
            OFS_TSEL: begin
               s_d.tsel = pwdata[7:0];
            end
            OFS_IRQ_EN: begin
               s_d.irq_en = pwdata[7:0];
            end
            OFS_IRQ_FLG: begin
               s_d.flag = pwdata[TMF_POS];
            end
            default: begin
            end
         endcase
      end

      // match flag: set wins over clear
      if (roll) begin
         s_d.flag = 1'b1;
      end
   end

   // RULE14 all registers reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= REGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.st[1];
   assign pslverr = s_q.slverr;

   ////////////////////////////////////////////////////////////////////////////////
   // RULE13 timing from pclk
   spd_prescaler #(
      .CNT_W(PSC_W)
   ) u_psc (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .clr(tcount_wr),
      .sel(s_q.tctrl[PSC_POS +: 2]),
      .tick(tick),
      .low(tb_low)
   );

   // RULE11 no match, pin unchanged
   spd_pin_drv u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .set(set_pin),
      .clr(hit),
      .off(!pwm_on),
      .en(pwm_on),
      .hold(sleep_req),
      .pin(pwm_output_pin),
      .oe_n(pwm_output_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_roll_clear;
      @(posedge pclk) disable iff (!presetn)
         roll && !tcount_wr |=> s_q.tmr == 8'h00;
   endproperty
   a_roll_clear: assert property (p_roll_clear) // RULE2
      else $error("timer not cleared at period match");

   property p_shadow_load;
      @(posedge pclk) disable iff (!presetn)
         roll && pwm_on |=> cmp == $past(duty);
   endproperty
   a_shadow_load: assert property (p_shadow_load) // RULE7
      else $error("duty not copied into shadow at rollover");

   property p_defer;
      @(posedge pclk) disable iff (!presetn)
         pwm_on && !roll |=> $stable(cmp);
   endproperty
   a_defer: assert property (p_defer) // RULE5
      else $error("shadow changed mid-period");

   property p_shadow_ro;
      @(posedge pclk) disable iff (!presetn)
         wr && paddr == OFS_SHADOW && pwm_on && !roll |=> $stable(s_q.shadow);
   endproperty
   a_shadow_ro: assert property (p_shadow_ro) // RULE6
      else $error("shadow written in pwm mode");

   sequence s_period_start;
      set_pin && !sleep_req;
   endsequence

   property p_set_pin;
      @(posedge pclk) disable iff (!presetn)
         s_period_start |=> pwm_output_pin && !pwm_output_oe_n;
   endproperty
   a_set_pin: assert property (p_set_pin) // RULE3
      else $error("pin not set at period start");

   property p_zero_duty;
      @(posedge pclk) disable iff (!presetn)
         roll && duty == 10'h000 |=> !set_pin ##1 !$rose(pwm_output_pin);
   endproperty
   a_zero_duty: assert property (p_zero_duty) // RULE3
      else $error("pin set with zero duty");

   property p_hit_clear;
      @(posedge pclk) disable iff (!presetn)
         hit && !set_pin && !sleep_req |=> !pwm_output_pin;
   endproperty
   a_hit_clear: assert property (p_hit_clear) // RULE9
      else $error("pin not cleared at duty match");

   property p_wide_keep;
      @(posedge pclk) disable iff (!presetn)
         pwm_on && (cmp > {s_q.period, 2'h3}) && !roll && !tcount_wr
         |=> !$fell(pwm_output_pin);
   endproperty
   a_wide_keep: assert property (p_wide_keep) // RULE11
      else $error("pin cleared with duty beyond period");

   property p_stopped;
      @(posedge pclk) disable iff (!presetn)
         !s_q.tctrl[RUN_POS] && !tcount_wr |=> $stable(s_q.tmr);
   endproperty
   a_stopped: assert property (p_stopped) // RULE16
      else $error("timer moved with run bit clear");

   property p_sleep_freeze;
      @(posedge pclk) disable iff (!presetn)
         sleep_req && !wr |=> $stable(s_q.tmr) && $stable(cmp) && $stable(s_q.flag);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze) // RULE12
      else $error("state changed during sleep");

   property p_ready_one;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one)
      else $error("apb ready not a single cycle");

endmodule
`default_nettype wire

/* tb/spd_load_model.sv */
// spd_load_model: load on the pwm pin, measures pulse and period
// assumes: pin pulled low while the design does not drive it
`timescale 1ns/10ps
`default_nettype none
module spd_load_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic pin, // level from the design
   input wire logic oe_n, // pin driven when low
   output logic [15:0] high_len, // clocks high in last pulse
   output logic [15:0] period_len, // clocks between last two rises
   output logic [15:0] rises // rising edges seen
);
   logic line;
   logic line_q;
   logic [15:0] cnt_q;
   // pull-down when undriven
   assign line = oe_n ? 1'b0 : pin;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q <= 1'b0;
         cnt_q <= 16'h0;
         high_len <= 16'h0;
         period_len <= 16'h0;
         rises <= 16'h0;
      end else begin
         line_q <= line;
         cnt_q <= cnt_q + 16'h1;
         if (line && !line_q) begin
            period_len <= cnt_q;
            cnt_q <= 16'h1;
            rises <= rises + 16'h1;
         end
         if (!line && line_q) begin
            high_len <= cnt_q;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: self-checking bench of the pwm duty generator
// assumes: design files and load model compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import spd_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, sleep_req, err;
   logic pready, pslverr, pin, oe_n, pv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, c1;
   logic [15:0] high_len, period_len, rises, r0;
   int fail_count = 0;
   int n_tests = 0;
   // period_limit, duty, prescale select, high clocks, period clocks
   int rows [5][5] = '{'{3, 6, 0, 6, 16}, '{3, 5, 1, 20, 64}, '{1, 3, 2, 48, 128},
      '{0, 1, 3, 64, 256}, '{255, 1023, 0, 1023, 1024}};

   spd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .pwm_output_pin(pin),
      .pwm_output_oe_n(oe_n));
   spd_load_model u_load (.pclk(pclk), .presetn(presetn), .pin(pin), .oe_n(oe_n),
      .high_len(high_len), .period_len(period_len), .rises(rises));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic rdy;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // look at the answer mid-cycle, act on the edge that samples it
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      chk({31'h0, rdy}, 32'h1);
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, 32'(d));
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cfg(input int pl, input int duty, input int psc);
      wr(OFS_TCTRL, 0);
      wr(OFS_IRQ_FLG, 0);
      wr(OFS_CTRL, 0);
      wr(OFS_TCOUNT, 0);
      wr(OFS_PERIOD, pl);
      wr(OFS_DUTY_HI, duty >> 2);
      wr(OFS_CTRL, 8'h0c | ((duty & 3) << 4));
      wr(OFS_TCTRL, psc);
      wr(OFS_TCTRL, 4 | psc);
   endtask

   initial begin
      #(8 * 40000);
      fail_count++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      sleep_req = 1'b0;
      cyc(5);
      presetn <= 1'b1;
      chk({30'h0, oe_n, pin}, 32'h2);
      for (int a = 0; a <= 32; a += 4) begin
         rdchk(8'(a), 32'h0);
      end
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(OFS_CTRL, 32'hff);
      rdchk(OFS_CTRL, 32'h3f);
      wr(OFS_CTRL, 0);
      $display("test reset done");
      foreach (rows[i]) begin
         cfg(rows[i][0], rows[i][1], rows[i][2]);
         cyc(3 * rows[i][4]);
         chk(32'(high_len), 32'(rows[i][3]));
         chk(32'(period_len), 32'(rows[i][4]));
         rdchk(OFS_IRQ_FLG, 32'h2);
         $display("test row %0d done", i);
      end
      wr(OFS_TCTRL, 0);
      apb(1'b0, OFS_TCOUNT, 32'h0);
      c1 = rd;
      cyc(10);
      rdchk(OFS_TCOUNT, c1);
      wr(OFS_SHADOW, 8'h11);
      wr(OFS_DUTY_HI, 8'h40);
      rdchk(OFS_SHADOW, 32'hff);
      wr(OFS_PERIOD, 3);
      wr(OFS_TCOUNT, 0);
      wr(OFS_TCTRL, 4);
      cyc(40);
      rdchk(OFS_SHADOW, 32'h40);
      $display("test double buffer done");
      cfg(3, 0, 0);
      cyc(20);
      r0 = rises;
      cyc(48);
      chk(32'(rises), 32'(r0));
      cfg(3, 20, 0);
      cyc(20);
      for (int k = 0; k < 8; k++) begin
         cyc(3);
         chk({31'h0, pin}, 32'h1);
      end
      $display("test duty edges done");
      cfg(3, 6, 0);
      cyc(20);
      sleep_req <= 1'b1;
      cyc(2);
      pv = pin;
      apb(1'b0, OFS_TCOUNT, 32'h0);
      c1 = rd;
      cyc(13);
      chk({31'h0, pin}, {31'h0, pv});
      rdchk(OFS_TCOUNT, c1);
      sleep_req <= 1'b0;
      cyc(5);
      apb(1'b0, OFS_TCOUNT, 32'h0);
      chk({31'h0, rd !== c1}, 32'h1);
      $display("test sleep done");
      wr(OFS_CTRL, 0);
      cyc(2);
      chk({30'h0, oe_n, pin}, 32'h2);
      cfg(3, 20, 0);
      cyc(20);
      presetn <= 1'b0;
      cyc(2);
      chk({30'h0, oe_n, pin}, 32'h2);
      presetn <= 1'b1;
      rdchk(OFS_PERIOD, 32'h0);
      rdchk(OFS_CTRL, 32'h0);
      $display("test mode off and reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
